// ===== mit_defs.svh
// Purpose: constants of the memory integrity trap unit
// Assumes: 16-bit APB byte addresses, 32-bit data
// Notes: definitions only
`ifndef MIT_DEFS_SVH
`define MIT_DEFS_SVH
`define MIT_OFF_DATA_ASYNC_ERROR_INFO 16'h9018
`define MIT_OFF_DLOC 16'h901c
`define MIT_OFF_PADR 16'h9210
`define MIT_OFF_PINF 16'h9214
`define MIT_OFF_STAT 16'h9300
`define MIT_OFF_MASK 16'h9304
`define MIT_OFF_CTRL 16'h9308
`define MIT_RST_WORD 32'h0000_0000
`define MIT_RST_FIVE 5'h00
`define MIT_TRAP_CLASS 3'h4
`define MIT_TIN_PROG 8'h05
`define MIT_TIN_DATA 8'h06
// Status bits
`define MIT_ST_PROG 0
`define MIT_ST_DATA 1
`define MIT_ST_STORE 2
`define MIT_ST_RES 3
`define MIT_ST_UNRES 4
// Info word fields
`define MIT_INF_UNC 3:0
`define MIT_INF_COR 7:4
`define MIT_INF_RES 8
`define MIT_INF_STORE 9
`define MIT_CTRL_WB 0
`endif

// ===== mit_pkg.sv
// Purpose: types of the memory integrity trap unit
// Assumes: nothing
// Notes: write-back owner, Gray coded
package mit_pkg;
    typedef enum logic [1:0] {
        MIT_WB_IDLE = 2'b00,
        MIT_WB_PROG = 2'b01,
        MIT_WB_DATA = 2'b11
    } mit_wb_t;
endpackage

// ===== mit_traps.sv
// Purpose: integrity error classes, traps and error registers
// Assumes: checker flags arrive on pclk, one flag per byte element
// Notes: data trap is synchronous; uncorrectable store errors also raise the async trap
//
// Register access over APB is this design's own decision.
`include "mit_defs.svh"
module mit_traps (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Instruction memory read
    input wire logic pf_valid,
    input wire logic [31:0] pf_addr,
    input wire logic [31:0] pf_raw,
    input wire logic [31:0] pf_fix,
    input wire logic [3:0] pf_cor,
    input wire logic [3:0] pf_unc,
    // Data memory read
    input wire logic dm_valid,
    input wire logic dm_store,
    input wire logic [31:0] dm_addr,
    input wire logic [31:0] dm_raw,
    input wire logic [31:0] dm_fix,
    input wire logic [3:0] dm_cor,
    input wire logic [3:0] dm_unc,
    // Core side
    input wire logic nmi_req,
    output logic core_pf_valid,
    output logic [31:0] core_pf_data,
    output logic core_dm_valid,
    output logic [31:0] core_dm_data,
    output logic trap_valid,
    output logic [2:0] trap_class,
    output logic [7:0] trap_tin,
    output logic [31:0] trap_addr,
    output logic store_trap,
    // Memory write-back
    output logic wb_valid,
    output logic wb_prog,
    output logic [31:0] wb_addr,
    output logic [31:0] wb_data,
    // Interrupt
    output logic irq
);
    import mit_pkg::*;

    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] data_async_error_info_reg;
    logic [31:0] dloc_reg;
    logic [31:0] pinf_reg;
    logic [31:0] padr_reg;
    logic [4:0] stat_reg;
    logic [4:0] mask_reg;
    logic [31:0] ctrl_reg;
    logic [4:0] stat_next;
    logic irq_reg;
    logic pfv_reg;
    logic [31:0] pfd_reg;
    logic dmv_reg;
    logic [31:0] dmd_reg;
    logic tv_reg;
    logic [7:0] tin_reg;
    logic [31:0] ta_reg;
    logic ph_reg;
    logic [31:0] pha_reg;
    logic st_reg;
    logic sp_reg;
    mit_wb_t wb_next;
    logic wbv_reg;
    logic wbp_reg;
    logic [31:0] wba_reg;
    logic [31:0] wbd_reg;

    // Error classes per access
    wire pf_is_unc = pf_valid && (|pf_unc);
    wire pf_is_cor = pf_valid && !(|pf_unc) && (|pf_cor);
    wire dm_is_unc = dm_valid && (|dm_unc);
    wire dm_is_cor = dm_valid && !(|dm_unc) && (|dm_cor);
    wire wb_en = ctrl_reg[`MIT_CTRL_WB];

    // Write-back owner: data side first
    assign wb_next = (wb_en && dm_is_cor) ? MIT_WB_DATA :
                     (wb_en && pf_is_cor) ? MIT_WB_PROG : MIT_WB_IDLE;
    wire pf_res = (wb_next == MIT_WB_PROG);
    wire dm_res = (wb_next == MIT_WB_DATA);

    // Data handed to the core
    wire [31:0] pf_out = pf_is_cor ? pf_fix : pf_raw;
    wire [31:0] dm_out = dm_is_cor ? dm_fix : dm_raw;

    // Info words, overwritten on each new error
    wire [31:0] pf_info = {22'h00_0000, 1'b0, pf_res, pf_cor, pf_unc};
    wire [31:0] dm_info = {22'h00_0000, dm_store, dm_res, dm_cor, dm_unc};
    wire pf_any = pf_is_unc || pf_is_cor;
    wire dm_any = dm_is_unc || dm_is_cor;
    wire st_err = dm_is_unc && dm_store;

    // Program trap held one cycle when a data trap wins
    wire prog_go = ph_reg || pf_is_unc;
    wire [31:0] prog_a = ph_reg ? pha_reg : pf_addr;
    wire hold_next = pf_is_unc && (ph_reg || dm_is_unc);

    // Store error trap waits behind a pending NMI
    wire sp_next = (sp_reg && nmi_req) || (st_err && nmi_req);
    wire st_next = !nmi_req && (sp_reg || st_err);

    // APB decode
    wire setup = psel && !penable;
    wire acc = psel && penable && pready_reg;
    wire wr = acc && pwrite;
    wire hit_data_async_error_info = (paddr == `MIT_OFF_DATA_ASYNC_ERROR_INFO);
    wire hit_dloc = (paddr == `MIT_OFF_DLOC);
    wire hit_padr = (paddr == `MIT_OFF_PADR);
    wire hit_pinf = (paddr == `MIT_OFF_PINF);
    wire hit_stat = (paddr == `MIT_OFF_STAT);
    wire hit_mask = (paddr == `MIT_OFF_MASK);
    wire hit_ctrl = (paddr == `MIT_OFF_CTRL);
    wire hit_ro = hit_data_async_error_info || hit_dloc || hit_padr || hit_pinf;
    wire hit_any = hit_ro || hit_stat || hit_mask || hit_ctrl;
    wire bad = !hit_any || (pwrite && hit_ro);
    wire [31:0] rd_word =
        hit_data_async_error_info ? data_async_error_info_reg :
        hit_dloc ? dloc_reg :
        hit_padr ? padr_reg :
        hit_pinf ? pinf_reg :
        hit_stat ? {27'h000_0000, stat_reg} :
        hit_mask ? {27'h000_0000, mask_reg} :
        hit_ctrl ? ctrl_reg : `MIT_RST_WORD;

    // Sticky events, set wins over a write-one clear
    wire [4:0] ev = {pf_is_cor && !pf_res || dm_is_cor && !dm_res,
                     pf_res || dm_res, st_err, dm_is_unc, pf_is_unc};
    wire [4:0] clr = (wr && hit_stat) ? pwdata[4:0] : `MIT_RST_FIVE;
    assign stat_next = (stat_reg & ~clr) | ev;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= `MIT_RST_WORD;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            prdata_reg <= (setup && !pwrite) ? rd_word : `MIT_RST_WORD;
            pready_reg <= setup;
            pslverr_reg <= setup && bad;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_reg <= `MIT_RST_FIVE;
            mask_reg <= `MIT_RST_FIVE;
            ctrl_reg <= `MIT_RST_WORD;
            irq_reg <= 1'b0;
        end
        else
        begin
            stat_reg <= stat_next;
            if (wr && hit_mask)
                mask_reg <= pwdata[4:0];
            if (wr && hit_ctrl)
                ctrl_reg <= {31'h0000_0000, pwdata[`MIT_CTRL_WB]};
            irq_reg <= |(stat_next & mask_reg);
        end
    end

    // Error registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pinf_reg <= `MIT_RST_WORD;
            padr_reg <= `MIT_RST_WORD;
            data_async_error_info_reg <= `MIT_RST_WORD;
            dloc_reg <= `MIT_RST_WORD;
        end
        else
        begin
            if (pf_any)
            begin
                pinf_reg <= pf_info;
                padr_reg <= pf_addr;
            end
            if (dm_any)
            begin
                data_async_error_info_reg <= dm_info;
                dloc_reg <= dm_addr;
            end
        end
    end

    // Core return path and traps
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pfv_reg <= 1'b0;
            pfd_reg <= `MIT_RST_WORD;
            dmv_reg <= 1'b0;
            dmd_reg <= `MIT_RST_WORD;
            tv_reg <= 1'b0;
            tin_reg <= `MIT_TIN_PROG;
            ta_reg <= `MIT_RST_WORD;
            ph_reg <= 1'b0;
            pha_reg <= `MIT_RST_WORD;
            st_reg <= 1'b0;
            sp_reg <= 1'b0;
        end
        else
        begin
            pfv_reg <= pf_valid;
            pfd_reg <= pf_out;
            dmv_reg <= dm_valid;
            dmd_reg <= dm_out;
            // Synchronous traps; none for correctable errors
            tv_reg <= dm_is_unc || prog_go;
            if (dm_is_unc)
            begin
                tin_reg <= `MIT_TIN_DATA;
                ta_reg <= dm_addr;
            end
            else if (prog_go)
            begin
                tin_reg <= `MIT_TIN_PROG;
                ta_reg <= prog_a;
            end
            ph_reg <= dm_is_unc ? prog_go : hold_next;
            if (dm_is_unc && !ph_reg)
                pha_reg <= pf_addr;
            else if (hold_next)
                pha_reg <= pf_addr;
            st_reg <= st_next;
            sp_reg <= sp_next;
        end
    end

    // Write-back to the faulty location
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wbv_reg <= 1'b0;
            wbp_reg <= 1'b0;
            wba_reg <= `MIT_RST_WORD;
            wbd_reg <= `MIT_RST_WORD;
        end
        else
        begin
            // Owner decoded ahead so both outputs leave a flop
            wbv_reg <= (wb_next != MIT_WB_IDLE);
            wbp_reg <= (wb_next == MIT_WB_PROG);
            wba_reg <= (wb_next == MIT_WB_DATA) ? dm_addr : pf_addr;
            wbd_reg <= (wb_next == MIT_WB_DATA) ? dm_fix : pf_fix;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign core_pf_valid = pfv_reg;
    assign core_pf_data = pfd_reg;
    assign core_dm_valid = dmv_reg;
    assign core_dm_data = dmd_reg;
    assign trap_valid = tv_reg;
    assign trap_class = `MIT_TRAP_CLASS;
    assign trap_tin = tin_reg;
    assign trap_addr = ta_reg;
    assign store_trap = st_reg;
    assign wb_valid = wbv_reg;
    assign wb_prog = wbp_reg;
    assign wb_addr = wba_reg;
    assign wb_data = wbd_reg;
    assign irq = irq_reg;

    default clocking mit_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_prog_trap_raise: assert property (
        pf_is_unc && !dm_is_unc && !ph_reg |=> trap_valid
            && trap_tin == `MIT_TIN_PROG && trap_addr == $past(pf_addr))
        else $error("program trap missing");
    chk_data_trap_raise: assert property (
        dm_is_unc |=> trap_valid && trap_tin == `MIT_TIN_DATA)
        else $error("data trap missing");
    chk_trap_class_four: assert property (
        trap_valid |-> trap_class == `MIT_TRAP_CLASS)
        else $error("trap class wrong");
    chk_held_prog_trap: assert property (
        pf_is_unc && dm_is_unc |=> ##1 trap_valid
            && trap_tin == `MIT_TIN_PROG)
        else $error("held program trap lost");
    chk_no_trap_cor: assert property (
        !pf_is_unc && !dm_is_unc && !ph_reg |=> !trap_valid)
        else $error("trap without uncorrectable error");
    chk_cor_data_out: assert property (
        dm_is_cor |=> core_dm_valid && core_dm_data == $past(dm_fix))
        else $error("corrected data not returned");
    chk_wb_resolved: assert property (
        dm_is_cor && wb_en |=> wb_valid && !wb_prog
            && wb_addr == $past(dm_addr) && stat_reg[`MIT_ST_RES])
        else $error("write-back missing");
    chk_pinf_update: assert property (
        pf_is_unc |=> pinf_reg[3:0] == $past(pf_unc)
            && padr_reg == $past(pf_addr))
        else $error("program info not captured");
    chk_dloc_update: assert property (
        dm_any |=> dloc_reg == $past(dm_addr))
        else $error("data location not captured");
    chk_store_nmi_order: assert property (
        st_err && !nmi_req |=> store_trap)
        else $error("store trap not raised");
    chk_store_nmi_wait: assert property (
        nmi_req |=> !store_trap)
        else $error("store trap passed the NMI");
    chk_apb_zero_wait: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("APB answer timing wrong");
    // Correction, write-back owner, status and APB refusal
    chk_cor_prog_out: assert property (
        pf_is_cor |=> core_pf_valid && core_pf_data == $past(pf_fix))
        else $error("corrected fetch data not returned");
    chk_unres_status: assert property (
        pf_is_cor && !wb_en |=> stat_reg[`MIT_ST_UNRES] && !wb_valid)
        else $error("unresolved error not flagged");
    chk_prog_wb_owner: assert property (
        pf_is_cor && !dm_is_cor && wb_en |=> wb_valid && wb_prog
            && wb_addr == $past(pf_addr))
        else $error("program write-back missing");
    chk_raw_on_unc: assert property (
        pf_is_unc |=> core_pf_data == $past(pf_raw))
        else $error("uncorrectable fetch data altered");
    chk_store_status: assert property (
        st_err |=> stat_reg[`MIT_ST_STORE])
        else $error("store error not flagged");
    chk_apb_refused: assert property (
        psel && !penable && pwrite && hit_ro |=> pready && pslverr)
        else $error("write to read-only register accepted");

    cov_prog_trap: cover property (pf_is_unc ##1 trap_valid);
    cov_data_store: cover property (st_err ##1 store_trap);
    cov_resolved: cover property (dm_is_cor && ctrl_reg[0] ##1 wb_valid);
    cov_both_traps: cover property (pf_is_unc && dm_is_unc ##2 trap_valid);
    cov_prog_resolved: cover property (pf_is_cor && wb_en ##1 wb_prog);
endmodule

// ===== mit_mem_model.sv
// Purpose: behavioural local instruction and data memory arrays
// Assumes: bench raises at most one request per side per cycle
// Notes: idle read lines toggle, except pf_valid and dm_valid which drop low; none hold stale values
module mit_mem_model (
    // Clock
    input wire logic pclk,
    // Bench requests
    input wire logic pf_req,
    input wire logic dm_req,
    input wire logic req_store,
    input wire logic [31:0] req_addr,
    input wire logic [3:0] req_cor,
    input wire logic [3:0] req_unc,
    // Write-back
    input wire logic wb_valid,
    input wire logic wb_prog,
    input wire logic [31:0] wb_addr,
    input wire logic [31:0] wb_data,
    // Read side
    output logic pf_valid,
    output logic dm_valid,
    output logic dm_store,
    output logic [31:0] addr,
    output logic [31:0] raw,
    output logic [31:0] fix,
    output logic [3:0] cor,
    output logic [3:0] unc
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] arr [2][16];
    logic [3:0] b;
    logic [31:0] word;
    assign b = req_cor | req_unc;
    assign word = arr[dm_req ? 1 : 0][req_addr[5:2]];
    initial
    begin
        {pf_valid, dm_valid, dm_store, cor, unc} = 11'h000;
        {addr, raw, fix} = 96'h0;
        for (int i = 0; i < 16; i++)
        begin
            arr[0][i] = 32'h5A00_0000 | 32'(i);
            arr[1][i] = 32'hC300_0000 | 32'(i);
        end
    end
    always @(posedge pclk)
    begin
        pf_valid <= pf_req;
        dm_valid <= dm_req;
        if (wb_valid)
            arr[wb_prog ? 0 : 1][wb_addr[5:2]] <= wb_data;
        if (pf_req || dm_req)
        begin
            dm_store <= req_store;
            addr <= req_addr;
            fix <= word;
            // Flip one bit in each faulty byte element
            raw <= word ^ {7'h00, b[3], 7'h00, b[2], 7'h00, b[1], 7'h00, b[0]};
            cor <= req_cor;
            unc <= req_unc;
        end
        else
            {dm_store, addr, raw, fix, cor, unc} <=
                ~{dm_store, addr, raw, fix, cor, unc};
    end
endmodule

// ===== mit_tb.sv
// Purpose: self-checking bench of the memory integrity trap unit
// Assumes: APB slave answers by pready, registered trap outputs
// Notes: memory arrays come from mit_mem_model
`include "mit_defs.svh"
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pf_req = 1'b0;
    logic dm_req = 1'b0;
    logic req_store = 1'b0;
    logic [31:0] req_addr = 32'h0000_0000;
    logic [3:0] req_cor = 4'h0;
    logic [3:0] req_unc = 4'h0;
    logic nmi_req = 1'b0;
    logic pready, pslverr, pf_valid, dm_valid, dm_store, rerr;
    logic core_pf_valid, core_dm_valid, trap_valid, store_trap;
    logic wb_valid, wb_prog, irq;
    logic [31:0] prdata, m_addr, m_raw, m_fix, rdata;
    logic [31:0] core_pf_data, core_dm_data, trap_addr, wb_addr, wb_data;
    logic [3:0] m_cor, m_unc;
    logic [2:0] trap_class;
    logic [7:0] trap_tin;
    int num_errors = 0;
    int checks = 0;
    always #25 pclk = ~pclk;
    mit_traps i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pf_valid(pf_valid), .pf_addr(m_addr), .pf_raw(m_raw),
        .pf_fix(m_fix), .pf_cor(m_cor), .pf_unc(m_unc),
        .dm_valid(dm_valid), .dm_store(dm_store), .dm_addr(m_addr),
        .dm_raw(m_raw), .dm_fix(m_fix), .dm_cor(m_cor), .dm_unc(m_unc),
        .nmi_req(nmi_req), .core_pf_valid(core_pf_valid),
        .core_pf_data(core_pf_data), .core_dm_valid(core_dm_valid),
        .core_dm_data(core_dm_data), .trap_valid(trap_valid),
        .trap_class(trap_class), .trap_tin(trap_tin),
        .trap_addr(trap_addr), .store_trap(store_trap),
        .wb_valid(wb_valid), .wb_prog(wb_prog), .wb_addr(wb_addr),
        .wb_data(wb_data), .irq(irq));
    mit_mem_model i_mem (.pclk(pclk), .pf_req(pf_req), .dm_req(dm_req),
        .req_store(req_store), .req_addr(req_addr), .req_cor(req_cor),
        .req_unc(req_unc), .wb_valid(wb_valid), .wb_prog(wb_prog),
        .wb_addr(wb_addr), .wb_data(wb_data), .pf_valid(pf_valid),
        .dm_valid(dm_valid), .dm_store(dm_store), .addr(m_addr),
        .raw(m_raw), .fix(m_fix), .cor(m_cor), .unc(m_unc));
    task automatic end_sim;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
        begin
            num_errors++;
            end_sim();
        end
    endtask
    // One access from the arrays; returns once the unit has answered
    task automatic acc(input logic p, d, s, input logic [31:0] a,
                       input logic [3:0] c, u);
        @(posedge pclk);
        pf_req <= p;
        dm_req <= d;
        req_store <= s;
        req_addr <= a;
        req_cor <= c;
        req_unc <= u;
        @(posedge pclk);
        pf_req <= 1'b0;
        dm_req <= 1'b0;
        @(posedge pclk);
        #1;
    endtask
    task automatic t_regs;
        apb(1'b0, `MIT_OFF_PINF, 32'h0000_0000);
        `CHK("pinf reset", 32'h0000_0000, rdata);
        `CHK("pinf ok", 1'b0, rerr);
        apb(1'b1, `MIT_OFF_PINF, 32'h1234_5678);
        `CHK("ro refused", 1'b1, rerr);
        apb(1'b0, `MIT_OFF_PINF, 32'h0000_0000);
        `CHK("ro kept", 32'h0000_0000, rdata);
        apb(1'b0, `MIT_OFF_DLOC, 32'h0000_0000);
        `CHK("dloc reset", 32'h0000_0000, rdata);
        apb(1'b0, 16'h9400, 32'h0000_0000);
        `CHK("unmapped", 1'b1, rerr);
        apb(1'b1, `MIT_OFF_MASK, 32'h0000_001F);
    endtask
    task automatic t_prog;
        acc(1'b1, 1'b0, 1'b0, 32'h0000_0008, 4'h0, 4'h8);
        `CHK("pf trap", 1'b1, trap_valid);
        `CHK("pf class", 3'h4, trap_class);
        `CHK("pf tin", 8'h05, trap_tin);
        `CHK("pf addr", 32'h0000_0008, trap_addr);
        `CHK("pf valid", 1'b1, core_pf_valid);
        `CHK("pf raw", 32'h5B00_0002, core_pf_data);
        @(posedge pclk);
        #1;
        `CHK("pf pulse", 1'b0, trap_valid);
        `CHK("irq set", 1'b1, irq);
        apb(1'b0, `MIT_OFF_PINF, 32'h0000_0000);
        `CHK("pinf", 32'h0000_0008, rdata);
        apb(1'b0, `MIT_OFF_PADR, 32'h0000_0000);
        `CHK("padr", 32'h0000_0008, rdata);
        apb(1'b1, `MIT_OFF_STAT, 32'h0000_001F);
        @(posedge pclk);
        #1;
        `CHK("irq clear", 1'b0, irq);
    endtask
    task automatic t_data;
        @(posedge pclk);
        nmi_req <= 1'b1;
        acc(1'b0, 1'b1, 1'b1, 32'h0000_0014, 4'h0, 4'h2);
        `CHK("dm tin", 8'h06, trap_tin);
        `CHK("dm sync", 1'b1, trap_valid);
        `CHK("dm addr", 32'h0000_0014, trap_addr);
        `CHK("dm valid", 1'b1, core_dm_valid);
        `CHK("dm raw", 32'hC300_0105, core_dm_data);
        `CHK("st held", 1'b0, store_trap);
        @(posedge pclk);
        nmi_req <= 1'b0;
        #1;
        `CHK("st wait", 1'b0, store_trap);
        repeat (4)
        begin
            @(posedge pclk);
            #1;
            if (store_trap === 1'b1)
                break;
        end
        `CHK("st trap", 1'b1, store_trap);
        apb(1'b0, `MIT_OFF_DATA_ASYNC_ERROR_INFO, 32'h0000_0000);
        `CHK("data_async_error_info", 32'h0000_0202, rdata);
        apb(1'b0, `MIT_OFF_DLOC, 32'h0000_0000);
        `CHK("dloc", 32'h0000_0014, rdata);
        apb(1'b1, `MIT_OFF_STAT, 32'h0000_001F);
    endtask
    task automatic t_cor;
        acc(1'b1, 1'b0, 1'b0, 32'h0000_000C, 4'h4, 4'h0);
        `CHK("cor none", 1'b0, trap_valid);
        `CHK("cor data", 32'h5A00_0003, core_pf_data);
        `CHK("no wb", 1'b0, wb_valid);
        apb(1'b0, `MIT_OFF_PINF, 32'h0000_0000);
        `CHK("pinf over", 32'h0000_0040, rdata);
        apb(1'b0, `MIT_OFF_STAT, 32'h0000_0000);
        `CHK("unres", 32'h0000_0010, rdata);
        apb(1'b1, `MIT_OFF_STAT, 32'h0000_001F);
        apb(1'b1, `MIT_OFF_CTRL, 32'h0000_0001);
        acc(1'b0, 1'b1, 1'b0, 32'h0000_0010, 4'h1, 4'h0);
        `CHK("dm fix", 32'hC300_0004, core_dm_data);
        `CHK("wb", 1'b1, wb_valid);
        `CHK("wb prog", 1'b0, wb_prog);
        `CHK("wb addr", 32'h0000_0010, wb_addr);
        `CHK("wb data", 32'hC300_0004, wb_data);
        apb(1'b0, `MIT_OFF_DATA_ASYNC_ERROR_INFO, 32'h0000_0000);
        `CHK("data_async_error_info res", 32'h0000_0110, rdata);
        acc(1'b1, 1'b0, 1'b0, 32'h0000_0018, 4'h2, 4'h0);
        `CHK("pf fix", 32'h5A00_0006, core_pf_data);
        `CHK("wb p", 1'b1, wb_valid);
        `CHK("wb p prog", 1'b1, wb_prog);
        `CHK("wb p addr", 32'h0000_0018, wb_addr);
        `CHK("wb p data", 32'h5A00_0006, wb_data);
        apb(1'b0, `MIT_OFF_PINF, 32'h0000_0000);
        `CHK("pinf res", 32'h0000_0120, rdata);
        apb(1'b0, `MIT_OFF_STAT, 32'h0000_0000);
        `CHK("resolved", 32'h0000_0008, rdata);
        apb(1'b1, `MIT_OFF_STAT, 32'h0000_001F);
    endtask
    task automatic t_both;
        acc(1'b1, 1'b1, 1'b0, 32'h0000_0004, 4'h0, 4'h1);
        `CHK("first", 8'h06, trap_tin);
        `CHK("first valid", 1'b1, trap_valid);
        @(posedge pclk);
        #1;
        `CHK("second", 1'b1, trap_valid);
        `CHK("second tin", 8'h05, trap_tin);
        `CHK("second addr", 32'h0000_0004, trap_addr);
    endtask
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_prog();
        t_data();
        t_cor();
        t_both();
        end_sim();
    end
endmodule
